/* ebcpu_defines.vh */
// Register addresses, reset values and field positions of the 8-bit core.
`ifndef EBCPU_DEFINES_VH
`define EBCPU_DEFINES_VH
`define EBCPU_SP_ADDR   8'h81
`define EBCPU_SP_RST    8'h07
`define EBCPU_DPL_ADDR  8'h82
`define EBCPU_DPH_ADDR  8'h83
`define EBCPU_PSW_ADDR  8'hD0
`define EBCPU_ACC_ADDR  8'hE0
`define EBCPU_B_ADDR    8'hF0
`define EBCPU_BIT_RAM   4'h2
`define EBCPU_CY        7
`define EBCPU_BANK_HI   4
`define EBCPU_BANK_LO   3
`define EBCPU_OP_SPARE  8'hA5
`define EBCPU_RST_PC    16'h0000
`endif

/* ebcpu_timing.v */
// Opcode to instruction length, base cycle count and conditional flag.
`timescale 1ns/1ns
module ebcpu_timing (
  input  wire [7:0] op,
  output wire [1:0] nbytes,
  output wire [3:0] ncyc,
  output wire       cond
);
  reg [6:0] t;

  assign cond   = t[6];
  assign nbytes = t[5:4];
  assign ncyc   = t[3:0];

  always @* begin
    t = {1'b0, 2'd1, 4'd1};
    case (op[3:0])
      4'h0: begin
        case (op[7:4])
          4'h0: t = {1'b0, 2'd1, 4'd1};
          4'h1, 4'h2, 4'h3: t = {1'b1, 2'd3, 4'd3};
          4'h4, 4'h5, 4'h6, 4'h7: t = {1'b1, 2'd2, 4'd2};
          4'h8: t = {1'b0, 2'd2, 4'd3};
          4'h9: t = {1'b0, 2'd3, 4'd3};
          4'hE, 4'hF: t = {1'b0, 2'd1, 4'd3};
          default: t = {1'b0, 2'd2, 4'd2};
        endcase
      end
      4'h1: t = {1'b0, 2'd2, 4'd3};
      4'h2: begin
        case (op[7:4])
          4'h0, 4'h1: t = {1'b0, 2'd3, 4'd4};
          4'h2, 4'h3: t = {1'b0, 2'd1, 4'd5};
          4'hE, 4'hF: t = {1'b0, 2'd1, 4'd3};
          default: t = {1'b0, 2'd2, 4'd2};
        endcase
      end
      4'h3: begin
        case (op[7:4])
          4'h4, 4'h5, 4'h6: t = {1'b0, 2'd3, 4'd3};
          4'h7: t = {1'b0, 2'd1, 4'd3};
          4'h8, 4'h9: t = {1'b0, 2'd1, 4'd3};
          4'hE, 4'hF: t = {1'b0, 2'd1, 4'd3};
          default: t = {1'b0, 2'd1, 4'd1};
        endcase
      end
      4'h4: begin
        case (op[7:4])
          4'h8: t = {1'b0, 2'd1, 4'd8};
          4'hA: t = {1'b0, 2'd1, 4'd4};
          4'hB: t = {1'b1, 2'd3, 4'd3};
          4'hF: t = {1'b0, 2'd1, 4'd2};
          4'h0, 4'h1, 4'hC, 4'hD, 4'hE: t = {1'b0, 2'd1, 4'd1};
          default: t = {1'b0, 2'd2, 4'd2};
        endcase
      end
      4'h5: begin
        case (op[7:4])
          4'h7, 4'h8: t = {1'b0, 2'd3, 4'd3};
          4'hA: t = {1'b0, 2'd1, 4'd1};
          4'hB: t = {1'b1, 2'd3, 4'd4};
          4'hD: t = {1'b1, 2'd3, 4'd3};
          default: t = {1'b0, 2'd2, 4'd2};
        endcase
      end
      4'h6, 4'h7: begin
        case (op[7:4])
          4'h7, 4'h8, 4'hA: t = {1'b0, 2'd2, 4'd2};
          4'hB: t = {1'b1, 2'd3, 4'd4};
          default: t = {1'b0, 2'd1, 4'd2};
        endcase
      end
      default: begin
        case (op[7:4])
          4'h7, 4'h8, 4'hA: t = {1'b0, 2'd2, 4'd2};
          4'hB: t = {1'b1, 2'd3, 4'd3};
          4'hD: t = {1'b1, 2'd2, 4'd2};
          default: t = {1'b0, 2'd1, 4'd1};
        endcase
      end
    endcase
  end
endmodule

/* ebcpu_addr.v */
// Operand address forming for bank, indirect, direct and bit operands.
`timescale 1ns/1ns
`include "ebcpu_defines.vh"
module ebcpu_addr (
  input  wire [1:0] bank,
  input  wire [2:0] sel,
  input  wire [7:0] b1,
  input  wire       bit_op,
  output wire [7:0] rn_addr,
  output wire [7:0] ri_addr,
  output wire [7:0] rd_addr,
  output wire       rd_sfr
);
  wire [7:0] bit_byte;

  assign rn_addr  = {3'b000, bank, sel};
  assign ri_addr  = {3'b000, bank, 2'b00, sel[0]};
  assign bit_byte = b1[7] ? {b1[7:3], 3'b000} : {`EBCPU_BIT_RAM, b1[6:3]};
  assign rd_addr  = bit_op ? bit_byte : b1;
  assign rd_sfr   = rd_addr[7];
endmodule

/* ebcpu_core.v */
// Instruction sequencer and executor of the 8-bit accumulator core.
`timescale 1ns/1ns
`include "ebcpu_defines.vh"
module ebcpu_core (
  input  wire        CLK_SYS,
  input  wire        RST,
  input  wire [7:0]  PM_DATA,
  input  wire [7:0]  XD_RDATA,
  output wire [15:0] PM_ADDR,
  output wire [15:0] XD_ADDR,
  output wire [7:0]  XD_WDATA,
  output wire        XD_WE,
  output wire        XD_RE,
  output wire        INSN_FETCH,
  output wire [7:0]  STACK_TOP
);
  reg  [7:0]  ram [0:255];
  reg  [15:0] pc_reg;
  reg  [15:0] pc_next;
  reg  [15:0] sixteen_bit_data_pointer_reg;
  reg  [15:0] sixteen_bit_data_pointer_next;
  reg  [15:0] pm_addr_reg;
  reg  [15:0] xd_addr_reg;
  reg  [7:0]  acc_reg;
  reg  [7:0]  acc_next;
  reg  [7:0]  b_reg;
  reg  [7:0]  b_next;
  reg  [7:0]  psw_reg;
  reg  [7:0]  psw_next;
  reg  [7:0]  sp_reg;
  reg  [7:0]  sp_next;
  reg  [7:0]  ib0_reg;
  reg  [7:0]  ib1_reg;
  reg  [7:0]  ib2_reg;
  reg  [7:0]  xd_wdata_reg;
  reg  [3:0]  cyc_reg;
  reg         wait_reg;
  reg         xd_we_reg;
  reg         xd_re_reg;
  reg         fetch_reg;
  reg         taken;
  reg         wa_en;
  reg         wa_sfr;
  reg  [7:0]  wa_addr;
  reg  [7:0]  wa_data;
  reg         wb_en;
  reg  [7:0]  sfr_val;
  wire [7:0]  op;
  wire [7:0]  b1;
  wire [7:0]  b2;
  wire [1:0]  nbytes;
  wire [3:0]  ncyc;
  wire        cond;
  wire        decide;
  wire [15:0] seq_pc;
  wire [7:0]  rel;
  wire [15:0] rel_pc;
  wire        bit_op;
  wire [7:0]  rn_addr;
  wire [7:0]  ri_addr;
  wire [7:0]  rd_addr;
  wire        rd_sfr;
  wire [7:0]  rn_val;
  wire [7:0]  ri_ptr;
  wire [7:0]  ri_val;
  wire [7:0]  rd_val;
  wire [3:0]  lo;
  wire [7:0]  src_val;
  wire [7:0]  tgt_addr;
  wire        tgt_sfr;
  wire        bit_val;
  wire [7:0]  bit_mask;
  wire [7:0]  lg_a;
  wire [7:0]  lg_b;
  wire [7:0]  lg_out;
  wire [7:0]  cmp_a;
  wire [7:0]  cmp_b;
  wire [7:0]  dec_val;
  wire        cy;
  wire [7:0]  sp_inc;
  wire        is_code_byte_move;
  wire        is_ext_data_move;
  wire [15:0] code_byte_move_addr;

  assign op      = (cyc_reg == 4'd0) ? PM_DATA : ib0_reg;
  assign b1      = (cyc_reg == 4'd1) ? PM_DATA : ib1_reg;
  assign b2      = (cyc_reg == 4'd2) ? PM_DATA : ib2_reg;
  assign lo      = op[3:0];
  assign cy      = psw_reg[`EBCPU_CY];
  assign sp_inc  = sp_reg + 8'h01;

  ebcpu_timing u_timing (
    .op     (op),
    .nbytes (nbytes),
    .ncyc   (ncyc),
    .cond   (cond)
  );

  assign bit_op = ((lo == 4'h0) && (op[7:4] == 4'h1 || op[7:4] == 4'h2 ||
                   op[7:4] == 4'h3 || op[7:4] == 4'hA || op[7:4] == 4'hB)) ||
                  ((lo == 4'h2) && (op[7:4] >= 4'h7) && (op[7:4] <= 4'hD));

  ebcpu_addr u_addr (
    .bank    (psw_reg[`EBCPU_BANK_HI:`EBCPU_BANK_LO]),
    .sel     (op[2:0]),
    .b1      (b1),
    .bit_op  (bit_op),
    .rn_addr (rn_addr),
    .ri_addr (ri_addr),
    .rd_addr (rd_addr),
    .rd_sfr  (rd_sfr)
  );

  // Untaken branches end at the base count; taken ones add a cycle.
  assign decide  = !wait_reg && (cyc_reg == ncyc - 4'd1);
  assign seq_pc  = pc_reg + {14'd0, nbytes};
  assign rel     = (nbytes == 2'd3) ? b2 : b1;
  assign rel_pc  = seq_pc + {{8{rel[7]}}, rel};
  assign rn_val  = ram[rn_addr];
  assign ri_ptr  = ram[ri_addr];
  assign ri_val  = ram[ri_ptr];
  assign rd_val  = rd_sfr ? sfr_val : ram[rd_addr];
  assign src_val = lo[3] ? rn_val : (lo[3:1] == 3'd3) ? ri_val :
                   (lo == 4'h5) ? rd_val : b1;
  assign tgt_addr = lo[3] ? rn_addr : (lo[3:1] == 3'd3) ? ri_ptr : b1;
  assign tgt_sfr  = (lo == 4'h5) && rd_sfr;
  assign bit_val  = rd_val[b1[2:0]];
  assign bit_mask = 8'h01 << b1[2:0];
  assign lg_a     = lo[3:1] == 3'd1 ? rd_val : acc_reg;
  assign lg_b     = lo == 4'h2 ? acc_reg : lo == 4'h3 ? b2 : src_val;
  assign lg_out   = op[7:4] == 4'h4 ? (lg_a | lg_b) :
                    op[7:4] == 4'h5 ? (lg_a & lg_b) : (lg_a ^ lg_b);
  assign cmp_a    = lo[3] ? rn_val : (lo[3:1] == 3'd3) ? ri_val : acc_reg;
  assign cmp_b    = (lo == 4'h5) ? rd_val : b1;
  assign dec_val  = src_val - 8'h01;
  assign is_code_byte_move  = (op == 8'h83) || (op == 8'h93);
  assign is_ext_data_move  = (op[7:5] == 3'b111) && (lo == 4'h0 || lo[3:1] == 3'd1);
  assign code_byte_move_addr = {8'h00, acc_reg} + (op[4] ? sixteen_bit_data_pointer_reg : pc_reg + 16'd1);

  always @* begin
    case (rd_addr)
      `EBCPU_SP_ADDR:  sfr_val = sp_reg;
      `EBCPU_DPL_ADDR: sfr_val = sixteen_bit_data_pointer_reg[7:0];
      `EBCPU_DPH_ADDR: sfr_val = sixteen_bit_data_pointer_reg[15:8];
      `EBCPU_PSW_ADDR: sfr_val = psw_reg;
      `EBCPU_ACC_ADDR: sfr_val = acc_reg;
      `EBCPU_B_ADDR:   sfr_val = b_reg;
      default:         sfr_val = 8'h00;
    endcase
  end

  always @* begin
    acc_next  = acc_reg;
    b_next    = b_reg;
    psw_next  = psw_reg;
    sixteen_bit_data_pointer_next = sixteen_bit_data_pointer_reg;
    sp_next   = sp_reg;
    pc_next   = seq_pc;
    taken     = 1'b0;
    wa_en     = 1'b0;
    wa_sfr    = 1'b0;
    wa_addr   = b1;
    wa_data   = 8'h00;
    wb_en     = 1'b0;
    casez (op)
      8'b???0_0001: pc_next = {seq_pc[15:11], op[7:5], b1};
      8'b???1_0001: begin
        pc_next = {seq_pc[15:11], op[7:5], b1};
        sp_next = sp_reg + 8'h02;
        wa_en   = 1'b1;
        wa_addr = sp_inc;
        wa_data = seq_pc[7:0];
        wb_en   = 1'b1;
      end
      8'h02: pc_next = {b1, b2};
      8'h12: begin
        pc_next = {b1, b2};
        sp_next = sp_reg + 8'h02;
        wa_en   = 1'b1;
        wa_addr = sp_inc;
        wa_data = seq_pc[7:0];
        wb_en   = 1'b1;
      end
      8'h22, 8'h32: begin
        pc_next = {ram[sp_reg], ram[sp_reg - 8'h01]};
        sp_next = sp_reg - 8'h02;
      end
      8'h03: acc_next = {acc_reg[0], acc_reg[7:1]};
      8'h13: begin
        acc_next = {cy, acc_reg[7:1]};
        psw_next[`EBCPU_CY] = acc_reg[0];
      end
      8'h23: acc_next = {acc_reg[6:0], acc_reg[7]};
      8'h33: begin
        acc_next = {acc_reg[6:0], cy};
        psw_next[`EBCPU_CY] = acc_reg[7];
      end
      8'h73: pc_next = sixteen_bit_data_pointer_reg + {8'h00, acc_reg};
      8'h80: pc_next = rel_pc;
      8'h10, 8'h20, 8'h30: begin
        taken = (op == 8'h30) ? !bit_val : bit_val;
        if (op == 8'h10 && bit_val) begin
          wa_en   = 1'b1;
          wa_sfr  = rd_sfr;
          wa_addr = rd_addr;
          wa_data = rd_val & ~bit_mask;
        end
      end
      8'h40: taken = cy;
      8'h50: taken = !cy;
      8'h60: taken = (acc_reg == 8'h00);
      8'h70: taken = (acc_reg != 8'h00);
      8'b0100_????, 8'b0101_????, 8'b0110_????: begin
        if (lo[3:1] == 3'd1) begin
          wa_en   = 1'b1;
          wa_sfr  = rd_sfr;
          wa_data = lg_out;
        end else begin
          acc_next = lg_out;
        end
      end
      8'h72: psw_next[`EBCPU_CY] = cy | bit_val;
      8'h82: psw_next[`EBCPU_CY] = cy & bit_val;
      8'hA0: psw_next[`EBCPU_CY] = cy | !bit_val;
      8'hB0: psw_next[`EBCPU_CY] = cy & !bit_val;
      8'hA2: psw_next[`EBCPU_CY] = bit_val;
      8'h92, 8'hB2, 8'hC2, 8'hD2: begin
        wa_en   = 1'b1;
        wa_sfr  = rd_sfr;
        wa_addr = rd_addr;
        case (op[7:4])
          4'h9:    wa_data = cy ? (rd_val | bit_mask) : (rd_val & ~bit_mask);
          4'hB:    wa_data = rd_val ^ bit_mask;
          4'hC:    wa_data = rd_val & ~bit_mask;
          default: wa_data = rd_val | bit_mask;
        endcase
      end
      8'hB3: psw_next[`EBCPU_CY] = !cy;
      8'hC3: psw_next[`EBCPU_CY] = 1'b0;
      8'hD3: psw_next[`EBCPU_CY] = 1'b1;
      8'h74: acc_next = b1;
      8'h75: begin
        wa_en   = 1'b1;
        wa_sfr  = b1[7];
        wa_data = b2;
      end
      8'b0111_011?, 8'b0111_1???: begin
        wa_en   = 1'b1;
        wa_addr = tgt_addr;
        wa_data = b1;
      end
      8'h83, 8'h93: acc_next = b1;
      8'h85: begin
        wa_en   = 1'b1;
        wa_sfr  = b2[7];
        wa_addr = b2;
        wa_data = rd_val;
      end
      8'b1000_011?, 8'b1000_1???: begin
        wa_en   = 1'b1;
        wa_sfr  = b1[7];
        wa_data = src_val;
      end
      8'h90: sixteen_bit_data_pointer_next = {b1, b2};
      8'b1010_011?, 8'b1010_1???: begin
        wa_en   = 1'b1;
        wa_addr = tgt_addr;
        wa_data = rd_val;
      end
      8'b1011_01??, 8'b1011_1???: begin
        taken = (cmp_a != cmp_b);
        psw_next[`EBCPU_CY] = (cmp_a < cmp_b);
      end
      8'hC0: begin
        sp_next = sp_inc;
        wa_en   = 1'b1;
        wa_addr = sp_inc;
        wa_data = rd_val;
      end
      8'hD0: begin
        sp_next = sp_reg - 8'h01;
        wa_en   = 1'b1;
        wa_sfr  = rd_sfr;
        wa_data = ram[sp_reg];
      end
      8'hC4: acc_next = {acc_reg[3:0], acc_reg[7:4]};
      8'b1100_01?1, 8'hC6, 8'b1100_1???: begin
        acc_next = src_val;
        wa_en    = 1'b1;
        wa_sfr   = tgt_sfr;
        wa_addr  = tgt_addr;
        wa_data  = acc_reg;
      end
      8'hD5, 8'b1101_1???: begin
        taken   = (dec_val != 8'h00);
        wa_en   = 1'b1;
        wa_sfr  = tgt_sfr;
        wa_addr = tgt_addr;
        wa_data = dec_val;
      end
      8'b1101_011?: begin
        acc_next = {acc_reg[7:4], ri_val[3:0]};
        wa_en    = 1'b1;
        wa_addr  = ri_ptr;
        wa_data  = {ri_val[7:4], acc_reg[3:0]};
      end
      8'hE0, 8'hE2, 8'hE3: acc_next = XD_RDATA;
      8'hE4: acc_next = 8'h00;
      8'hE5, 8'b1110_011?, 8'b1110_1???: acc_next = src_val;
      8'hF4: acc_next = ~acc_reg;
      8'hF5, 8'b1111_011?, 8'b1111_1???: begin
        wa_en   = 1'b1;
        wa_sfr  = tgt_sfr;
        wa_addr = tgt_addr;
        wa_data = acc_reg;
      end
      default: taken = 1'b0;
    endcase
    if (taken) begin
      pc_next = rel_pc;
    end
    if (wa_en && wa_sfr) begin
      case (wa_addr)
        `EBCPU_SP_ADDR:  sp_next = wa_data;
        `EBCPU_DPL_ADDR: sixteen_bit_data_pointer_next[7:0] = wa_data;
        `EBCPU_DPH_ADDR: sixteen_bit_data_pointer_next[15:8] = wa_data;
        `EBCPU_PSW_ADDR: psw_next = wa_data;
        `EBCPU_ACC_ADDR: acc_next = wa_data;
        `EBCPU_B_ADDR:   b_next = wa_data;
        default:         b_next = b_reg;
      endcase
    end
  end

  always @(posedge CLK_SYS) begin
    if (RST) begin
      pc_reg       <= `EBCPU_RST_PC;
      pm_addr_reg  <= `EBCPU_RST_PC;
      sixteen_bit_data_pointer_reg     <= 16'h0000;
      acc_reg      <= 8'h00;
      b_reg        <= 8'h00;
      psw_reg      <= 8'h00;
      sp_reg       <= `EBCPU_SP_RST;
      ib0_reg      <= 8'h00;
      ib1_reg      <= 8'h00;
      ib2_reg      <= 8'h00;
      cyc_reg      <= 4'd0;
      wait_reg     <= 1'b0;
      fetch_reg    <= 1'b1;
      xd_addr_reg  <= 16'h0000;
      xd_wdata_reg <= 8'h00;
      xd_we_reg    <= 1'b0;
      xd_re_reg    <= 1'b0;
    end else begin
      xd_we_reg <= 1'b0;
      xd_re_reg <= 1'b0;
      if (wait_reg) begin
        wait_reg  <= 1'b0;
        fetch_reg <= 1'b1;
      end else if (decide) begin
        cyc_reg     <= 4'd0;
        wait_reg    <= taken;
        fetch_reg   <= !taken;
        pc_reg      <= pc_next;
        pm_addr_reg <= pc_next;
        acc_reg     <= acc_next;
        b_reg       <= b_next;
        psw_reg     <= psw_next;
        sixteen_bit_data_pointer_reg    <= sixteen_bit_data_pointer_next;
        sp_reg      <= sp_next;
        if (wa_en && !wa_sfr) begin
          ram[wa_addr] <= wa_data;
        end
        if (wb_en) begin
          ram[sp_reg + 8'h02] <= seq_pc[15:8];
        end
      end else begin
        cyc_reg     <= cyc_reg + 4'd1;
        fetch_reg   <= 1'b0;
        pm_addr_reg <= pc_reg + {12'd0, cyc_reg} + 16'd1;
        case (cyc_reg)
          4'd0:    ib0_reg <= PM_DATA;
          4'd1:    ib1_reg <= PM_DATA;
          4'd2:    ib2_reg <= PM_DATA;
          default: ib2_reg <= ib2_reg;
        endcase
        if (cyc_reg == 4'd0 && is_code_byte_move) begin
          pm_addr_reg <= code_byte_move_addr;
        end
        if (cyc_reg == 4'd0 && is_ext_data_move) begin
          xd_addr_reg  <= op[1] ? {8'h00, ri_ptr} : sixteen_bit_data_pointer_reg;
          xd_wdata_reg <= acc_reg;
          xd_we_reg    <= op[4];
          xd_re_reg    <= !op[4];
        end
      end
    end
  end

  assign PM_ADDR    = pm_addr_reg;
  assign XD_ADDR    = xd_addr_reg;
  assign XD_WDATA   = xd_wdata_reg;
  assign XD_WE      = xd_we_reg;
  assign XD_RE      = xd_re_reg;
  assign INSN_FETCH = fetch_reg;
  assign STACK_TOP  = sp_reg;
endmodule

/* ebcpu_chk_assertions.sv */
// Port-level timing and stack checks for the 8-bit core.
`timescale 1ns/1ns
module ebcpu_chk (
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic [7:0]  PM_DATA,
  input wire logic [7:0]  XD_RDATA,
  input wire logic [15:0] PM_ADDR,
  input wire logic [15:0] XD_ADDR,
  input wire logic [7:0]  XD_WDATA,
  input wire logic        XD_WE,
  input wire logic        XD_RE,
  input wire logic        INSN_FETCH,
  input wire logic [7:0]  STACK_TOP
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  property p_reset;
    $fell(RST) |-> PM_ADDR == 16'h0000 && INSN_FETCH && STACK_TOP == 8'h07;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
  property p_xwr;
    INSN_FETCH && PM_DATA inside {8'hF0, 8'hF2, 8'hF3} |=> XD_WE && !XD_RE ##1 !XD_WE ##1 INSN_FETCH;
  endproperty
  a_xwr: assert property (p_xwr) else $error("external write timing wrong");
  property p_xrd;
    INSN_FETCH && PM_DATA inside {8'hE0, 8'hE2, 8'hE3} |=> XD_RE && !XD_WE ##1 !XD_RE ##1 INSN_FETCH;
  endproperty
  a_xrd: assert property (p_xrd) else $error("external read timing wrong");
  property p_x8;
    INSN_FETCH && PM_DATA inside {8'hE2, 8'hE3, 8'hF2, 8'hF3} |=> XD_ADDR[15:8] == 8'h00;
  endproperty
  a_x8: assert property (p_x8) else $error("short external address wrong");
  property p_nop;
    INSN_FETCH && PM_DATA inside {8'h00, 8'hA5} |=>
      INSN_FETCH && PM_ADDR == $past(PM_ADDR) + 16'h0001 && $stable(STACK_TOP);
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation wrong");
  property p_push;
    INSN_FETCH && PM_DATA == 8'hC0 |=>
      !INSN_FETCH ##1 INSN_FETCH && STACK_TOP == $past(STACK_TOP, 2) + 8'h01;
  endproperty
  a_push: assert property (p_push) else $error("push wrong");
  property p_pop;
    INSN_FETCH && PM_DATA == 8'hD0 |=>
      !INSN_FETCH ##1 INSN_FETCH && STACK_TOP == $past(STACK_TOP, 2) - 8'h01;
  endproperty
  a_pop: assert property (p_pop) else $error("pop wrong");
  property p_long;
    INSN_FETCH && PM_DATA inside {8'h02, 8'h12} |=> !INSN_FETCH [*3] ##1
      INSN_FETCH && PM_ADDR == {$past(PM_DATA, 3), $past(PM_DATA, 2)};
  endproperty
  a_long: assert property (p_long) else $error("long transfer wrong");
  property p_short;
    INSN_FETCH && PM_DATA == 8'h80 |=> !INSN_FETCH [*2] ##1 INSN_FETCH && PM_ADDR ==
      $past(PM_ADDR, 3) + 16'h0002 + {{8{$past(PM_DATA[7], 2)}}, $past(PM_DATA, 2)};
  endproperty
  a_short: assert property (p_short) else $error("short jump wrong");
  property p_paged;
    INSN_FETCH && PM_DATA[3:0] == 4'h1 |=> !INSN_FETCH [*2] ##1 INSN_FETCH &&
      PM_ADDR[10:0] == {$past(PM_DATA[7:5], 3), $past(PM_DATA, 2)} &&
      {PM_ADDR[15:11], 11'h000} == (($past(PM_ADDR, 3) + 16'h0002) & 16'hF800);
  endproperty
  a_paged: assert property (p_paged) else $error("paged transfer wrong");
  property p_ret;
    INSN_FETCH && PM_DATA inside {8'h22, 8'h32} |=> !INSN_FETCH [*4] ##1
      INSN_FETCH && STACK_TOP == $past(STACK_TOP, 5) - 8'h02;
  endproperty
  a_ret: assert property (p_ret) else $error("return wrong");
  c_call: cover property (INSN_FETCH && PM_DATA == 8'h12);
  c_xwr: cover property (XD_WE);
  c_wait: cover property (INSN_FETCH && PM_DATA == 8'hDA ##2 !INSN_FETCH);
endmodule
bind ebcpu_core ebcpu_chk u_chk (.CLK_SYS(CLK_SYS), .RST(RST), .PM_DATA(PM_DATA),
  .XD_RDATA(XD_RDATA), .PM_ADDR(PM_ADDR), .XD_ADDR(XD_ADDR), .XD_WDATA(XD_WDATA),
  .XD_WE(XD_WE), .XD_RE(XD_RE), .INSN_FETCH(INSN_FETCH), .STACK_TOP(STACK_TOP));

/* ebcpu_mem_model.sv */
// Program memory and external data memory seen by the core.
`timescale 1ns/1ns
module ebcpu_mem_model (
  input  wire logic        clk,
  input  wire logic [15:0] pm_addr,
  output logic      [7:0]  pm_data,
  input  wire logic [15:0] xd_addr,
  input  wire logic [7:0]  xd_wdata,
  input  wire logic        xd_we,
  input  wire logic        xd_re,
  output logic      [7:0]  xd_rdata
);
  logic [7:0]  rom [0:65535];
  logic [15:0] wr_addr;
  logic [7:0]  wr_data;
  assign pm_data = rom[pm_addr];
  initial xd_rdata = 8'h00;
  // Read data is valid only in the cycle after the strobe, else it toggles.
  always @(posedge clk) begin
    if (xd_re)
      xd_rdata <= xd_addr[7:0] ^ xd_addr[15:8] ^ 8'h3C;
    else
      xd_rdata <= ~xd_rdata;
    if (xd_we) begin
      wr_addr <= xd_addr;
      wr_data <= xd_wdata;
    end
  end
endmodule

/* tb_top.sv */
// Self-checking bench: fetch trace timing, stack pointer and external data.
`timescale 1ns/1ns
module tb_top;
  logic        clk_sys;
  logic        rst;
  logic [7:0]  pm_data;
  logic [7:0]  xd_rdata;
  logic [15:0] pm_addr;
  logic [15:0] xd_addr;
  logic [7:0]  xd_wdata;
  logic        xd_we;
  logic        xd_re;
  logic        insn_fetch;
  logic [7:0]  stack_top;
  logic [15:0] exp_a [$];
  logic [15:0] exp_c [$];
  logic [15:0] pc;
  logic [15:0] cyc;
  logic [7:0]  sp;
  int          fi;
  int          mark;
  int          n_mismatch;
  int          samples_checked;
  logic [15:0] tbl [0:44] = '{16'h0011, 16'hA511, 16'h6811, 16'h6522, 16'h6422, 16'h6222,
    16'h6333, 16'h6612, 16'hE411, 16'hF412, 16'h2311, 16'h3311, 16'h0311, 16'h1311, 16'hC411,
    16'hEB11, 16'hE522, 16'h7422, 16'hFB11, 16'h7B22, 16'h8533, 16'h7533, 16'hCB11, 16'hC522,
    16'hC612, 16'hD612, 16'hC311, 16'hD311, 16'hB311, 16'hC222, 16'hD222, 16'hB222, 16'h8222,
    16'hA022, 16'hA222, 16'h9222, 16'h8313, 16'h9313, 16'hE213, 16'hF213, 16'hE013, 16'hF013,
    16'hC022, 16'hD022, 16'h9033};
  ebcpu_core dut (.CLK_SYS(clk_sys), .RST(rst), .PM_DATA(pm_data), .XD_RDATA(xd_rdata),
    .PM_ADDR(pm_addr), .XD_ADDR(xd_addr), .XD_WDATA(xd_wdata), .XD_WE(xd_we), .XD_RE(xd_re),
    .INSN_FETCH(insn_fetch), .STACK_TOP(stack_top));
  ebcpu_mem_model mem (.clk(clk_sys), .pm_addr(pm_addr), .pm_data(pm_data), .xd_addr(xd_addr),
    .xd_wdata(xd_wdata), .xd_we(xd_we), .xd_re(xd_re), .xd_rdata(xd_rdata));
  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;
  function automatic logic [7:0] exp_xd(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic emit(input logic [7:0] op, b1, b2, input int n, c);
    mem.rom[pc] = op;
    if (n > 1) mem.rom[pc + 16'h0001] = b1;
    if (n > 2) mem.rom[pc + 16'h0002] = b2;
    exp_a.push_back(pc);
    exp_c.push_back(16'(c));
    pc = pc + 16'(n);
  endtask
  task automatic build;
    logic [15:0] e;
    logic [7:0]  b1;
    logic [7:0]  b2;
    emit(8'h78, 8'h40, 8'h00, 2, 2);
    for (int i = 0; i < 40; i++) begin
      e = tbl[$urandom_range(44)];
      if (e[15:8] == 8'hD0 && sp == 8'h07) e = 16'hC022;
      if (e[15:8] == 8'hC0) sp = sp + 8'h01;
      if (e[15:8] == 8'hD0) sp = sp - 8'h01;
      b1 = 8'h30 + 8'($urandom_range(79));
      b2 = 8'h30 + 8'($urandom_range(79));
      emit(e[15:8], b1, b2, e[7:4], e[3:0]);
    end
    mark = exp_a.size();
    emit(8'hC3, 8'h00, 8'h00, 1, 1);
    emit(8'hD3, 8'h00, 8'h00, 1, 1);
    emit(8'hB3, 8'h00, 8'h00, 1, 1);
    emit(8'hA5, 8'h00, 8'h00, 1, 1);
    emit(8'h40, 8'h02, 8'h00, 2, 2);
    emit(8'h50, 8'h02, 8'h00, 2, 3);
    pc = pc + 16'h0002;
    emit(8'hE4, 8'h00, 8'h00, 1, 1);
    emit(8'h60, 8'h01, 8'h00, 2, 3);
    pc = pc + 16'h0001;
    emit(8'h70, 8'h05, 8'h00, 2, 2);
    emit(8'h20, 8'hE0, 8'h05, 3, 3);
    emit(8'h30, 8'hE0, 8'h00, 3, 4);
    emit(8'hD2, 8'h00, 8'h00, 2, 2);
    emit(8'h10, 8'h00, 8'h00, 3, 4);
    emit(8'h20, 8'h00, 8'h05, 3, 3);
    emit(8'hB4, 8'h00, 8'h05, 3, 3);
    emit(8'hB4, 8'h01, 8'h00, 3, 4);
    emit(8'h7A, 8'h02, 8'h00, 2, 2);
    emit(8'hDA, 8'hFE, 8'h00, 2, 3);
    pc = pc - 16'h0002;
    emit(8'hDA, 8'hFE, 8'h00, 2, 2);
    emit(8'h75, 8'h81, 8'h50, 3, 3);
    emit(8'hC0, 8'h30, 8'h00, 2, 2);
    emit(8'hD0, 8'h31, 8'h00, 2, 2);
    emit(8'h12, 8'h08, 8'h00, 3, 4);
    e = pc;
    pc = 16'h0800;
    emit(8'h22, 8'h00, 8'h00, 1, 5);
    pc = e;
    emit(8'hF1, 8'hF0, 8'h00, 2, 3);
    e = pc;
    pc = 16'h07F0;
    emit(8'h32, 8'h00, 8'h00, 1, 5);
    pc = e;
    emit(8'hE1, 8'h00, 8'h00, 2, 3);
    pc = 16'h0700;
    emit(8'h90, 8'h12, 8'h34, 3, 3);
    emit(8'hE2, 8'h00, 8'h00, 1, 3);
    emit(8'hF0, 8'h00, 8'h00, 1, 3);
    emit(8'h74, 8'h05, 8'h00, 2, 2);
    emit(8'h90, 8'h07, 8'h20, 3, 3);
    emit(8'h73, 8'h00, 8'h00, 1, 3);
    pc = 16'h0725;
    emit(8'h80, 8'hFE, 8'h00, 2, 3);
    pc = 16'h0725;
    emit(8'h80, 8'hFE, 8'h00, 2, 3);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(negedge clk_sys) begin
    if (rst === 1'b0 && insn_fetch === 1'b1) begin
      if (fi > 0 && fi <= exp_c.size()) chk("cycles", exp_c[fi-1], cyc);
      if (fi < exp_a.size()) chk("fetch_addr", exp_a[fi], pm_addr);
      if (fi == mark) chk("stack_random", {8'h00, sp}, {8'h00, stack_top});
      fi++;
      cyc = 16'h0001;
    end
    else
      cyc = cyc + 16'h0001;
  end
  initial begin
    rst = 1'b1;
    fi = 0;
    n_mismatch = 0;
    samples_checked = 0;
    cyc = 16'h0000;
    sp = 8'h07;
    pc = 16'h0000;
    void'($urandom(32'hae792959));
    for (int i = 0; i < 65536; i++) mem.rom[i] = 8'h00;
    build;
    repeat (8) @(posedge clk_sys);
    #5;
    chk("reset_pc", 16'h0000, pm_addr);
    chk("reset_sp", 16'h0007, {8'h00, stack_top});
    rst = 1'b0;
    $display("test reset done");
    for (int i = 0; i < 3000 && fi < exp_a.size(); i++) @(posedge clk_sys);
    chk("trace_len", 16'(exp_a.size()), 16'(fi));
    $display("test trace done");
    chk("stack_top", 16'h0050, {8'h00, stack_top});
    chk("xd_wr_addr", 16'h1234, mem.wr_addr);
    chk("xd_wr_data", {8'h00, exp_xd(16'h0040)}, {8'h00, mem.wr_data});
    $display("test stack_and_xdata done");
    summarize;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    $display("watchdog expired");
    summarize;
  end
endmodule
